// ==== core/swrc_pkg.sv ====
package swrc_pkg;

    // Register port geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // Register offsets
    localparam logic [ADDR_W-1:0] OFS_SLEEP_CMD  = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_NORMAL_CMD = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_SLEEP_CFG  = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_SUPPLY_MON = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_STATUS     = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_MASK       = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_IO_CFG     = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_MODE       = 8'h1c;

    // Sleep configuration fields
    localparam int DOZE_REQUEST_BIT = 0;

    // Supply monitor control fields
    localparam int RESET_OUTPUT_ENABLE = 0;
    localparam int PUMP_ENABLE_BIT     = 1;
    localparam logic [1:0] SUPPLY_MON_RST = 2'h0;

    // Status and mask fields
    localparam int ST_W          = 4;
    localparam int ST_WAKE_PIN   = 0;
    localparam int ST_DAY_ALARM  = 1;
    localparam int ST_LOW_SUPPLY = 2;
    localparam int ST_CLK_LOCKED = 3;
    localparam logic [ST_W-1:0] MASK_RST = 4'h7;

    // User I/O configuration: low nibble direction, high nibble pull-ups
    localparam int IO_N = 4;
    localparam logic [IO_N-1:0] IO_DIR_RST  = 4'h0;
    localparam logic [IO_N-1:0] IO_PULL_RST = 4'hf;

    // Mode register fields
    localparam int MD_SLEEP    = 0;
    localparam int MD_SHUTDOWN = 1;
    localparam int MD_PIN_DOZE = 2;
    localparam int MD_RESET_N  = 3;

    // Synchronised input bundle
    localparam int SYNC_W      = 9;
    localparam int IN_DOZE_PIN = 0;
    localparam int IN_WAKE_PIN = 1;
    localparam int IN_ALARM    = 2;
    localparam int IN_CLK32K   = 3;
    localparam int IN_LOW_SUP  = 4;
    localparam int IN_WDOG     = 5;
    localparam int IN_XTAL     = 6;
    localparam int IN_CLK32_OK = 7;
    localparam int IN_LOCKED   = 8;

endpackage : swrc_pkg

// ==== core/swrc_sync_if.sv ====
`timescale 1ns/1ns
interface swrc_sync_if #(
    parameter int W = 1
);
    logic [W-1:0] raw;
    logic [W-1:0] lvl;
    logic [W-1:0] rise;

    modport src (
        input  raw,
        output lvl,
        output rise
    );
    modport user (
        output raw,
        input  lvl,
        input  rise
    );
endinterface : swrc_sync_if

// ==== core/swrc_sync.sv ====
`timescale 1ns/1ns
module swrc_sync #(
    parameter int W = 1
) (
    input  wire logic  clk_i,
    input  wire logic  rst_i,
    swrc_sync_if.src   sy
);
    import swrc_pkg::*;

    logic [W-1:0] s1_ff;
    logic [W-1:0] s2_ff;
    logic [W-1:0] s3_ff;
    logic [W-1:0] nxt_s1;
    logic [W-1:0] nxt_s2;
    logic [W-1:0] nxt_s3;

    // First stage feeds only the second; edges come from stages two and three
    always_comb begin
        nxt_s1 = sy.raw;
        nxt_s2 = s1_ff;
        nxt_s3 = s2_ff;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
        end else begin
            s1_ff <= nxt_s1;
            s2_ff <= nxt_s2;
            s3_ff <= nxt_s3;
        end
    end

    assign sy.lvl  = s2_ff;
    assign sy.rise = s2_ff & ~s3_ff;

endmodule : swrc_sync

// ==== core/swrc_top.sv ====
// What this block does
// - A write to the sleep command address sets the shutdown flag and enters sleep.
// - Pin doze request forces sleep, leaves shutdown flag alone, overrides writes and wakes.
// - Writing one to the doze request bit sets the shutdown flag.
// - Sleep mode is the OR of pin doze request and shutdown flag.
// - Releasing the pin doze request with shutdown clear returns to normal mode.
// - With pin released, a normal command write clears shutdown and wakes.
// - With pin released, asserting the wake input function wakes the device.
// - With pin released, a day alarm match wakes the device.
// - A wake event in normal mode is only recorded in status.
// - Reset output low on power-on, unguarded supply trip, watchdog, crystal, clock not ready.
// - With supply reset disabled, low supply is reported by flag and interrupt.
// - Clearing the pump enable bit turns the charge pump doubler off.
// - Low supply flag clears on status read unless the condition persists.
// - After reset user pins are inputs with pull-ups; all interrupts but clock-locked masked.
// - In sleep only interface, registers, wake logic, supervisor and 32kHz stay powered.
`timescale 1ns/1ns
module swrc_top (
    input  wire logic                        clk_i,
    input  wire logic                        rst_i,
    // Register port
    input  wire logic [swrc_pkg::ADDR_W-1:0] addr_i,
    input  wire logic [swrc_pkg::DATA_W-1:0] wdata_i,
    input  wire logic                        wr_i,
    input  wire logic                        rd_i,
    output logic      [swrc_pkg::DATA_W-1:0] rdata_o,
    // Pins and monitor inputs, all asynchronous
    input  wire logic                        doze_pin_i,
    input  wire logic                        wake_pin_i,
    input  wire logic                        day_alarm_i,
    input  wire logic                        clk32k_i,
    input  wire logic                        supply_low_i,
    input  wire logic                        watchdog_expired_i,
    input  wire logic                        xtal_attached_i,
    input  wire logic                        clk32_ready_i,
    input  wire logic                        fast_clock_locked_i,
    // Outputs
    output logic                             reset_n_o,
    output logic                             irq_o,
    output logic                             sleep_mode_o,
    output logic                             block_power_o,
    output logic                             pump_on_o,
    output logic      [swrc_pkg::IO_N-1:0]   io_dir_o,
    output logic      [swrc_pkg::IO_N-1:0]   io_pullup_o
);
    import swrc_pkg::*;

    swrc_sync_if #(.W(SYNC_W)) sy ();

    // All outside inputs pass the three-stage synchroniser
    assign sy.raw[IN_DOZE_PIN] = doze_pin_i;
    assign sy.raw[IN_WAKE_PIN] = wake_pin_i;
    assign sy.raw[IN_ALARM]    = day_alarm_i;
    assign sy.raw[IN_CLK32K]   = clk32k_i;
    assign sy.raw[IN_LOW_SUP]  = supply_low_i;
    assign sy.raw[IN_WDOG]     = watchdog_expired_i;
    assign sy.raw[IN_XTAL]     = xtal_attached_i;
    assign sy.raw[IN_CLK32_OK] = clk32_ready_i;
    assign sy.raw[IN_LOCKED]   = fast_clock_locked_i;

    swrc_sync #(
        .W     (SYNC_W)
    ) u_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .sy    (sy.src)
    );

    // Decoded strobes
    logic wr_sleep;
    logic wr_normal;
    logic wr_cfg;
    logic wr_mon;
    logic wr_status;
    logic wr_mask;
    logic wr_io;
    logic rd_status;

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    assign wr_sleep  = wr_i & hit(addr_i, OFS_SLEEP_CMD);
    assign wr_normal = wr_i & hit(addr_i, OFS_NORMAL_CMD);
    assign wr_cfg    = wr_i & hit(addr_i, OFS_SLEEP_CFG);
    assign wr_mon    = wr_i & hit(addr_i, OFS_SUPPLY_MON);
    assign wr_status = wr_i & hit(addr_i, OFS_STATUS);
    assign wr_mask   = wr_i & hit(addr_i, OFS_MASK);
    assign wr_io     = wr_i & hit(addr_i, OFS_IO_CFG);
    assign rd_status = rd_i & hit(addr_i, OFS_STATUS);

    // Synchronised views
    logic pin_doze;
    logic tick32;
    logic wake_evt;
    logic alarm_evt;
    logic low_sup;

    assign pin_doze  = sy.lvl[IN_DOZE_PIN];
    assign tick32    = sy.rise[IN_CLK32K];
    assign wake_evt  = sy.rise[IN_WAKE_PIN];
    assign alarm_evt = sy.rise[IN_ALARM];
    assign low_sup   = sy.lvl[IN_LOW_SUP];

    // Mode state
    logic shutdown_ff;
    logic sleep_ff;
    logic nxt_shutdown;
    logic nxt_sleep;

    // Set requests beat clears; the pin request blocks every clear path
    always_comb begin
        nxt_shutdown = shutdown_ff;
        nxt_sleep    = sleep_ff;
        if (!pin_doze && (wr_normal || wake_evt || alarm_evt)) begin
            nxt_shutdown = 1'b0;
        end
        if (wr_sleep) begin
            nxt_shutdown = 1'b1;
        end
        if (wr_cfg && wdata_i[DOZE_REQUEST_BIT]) begin
            nxt_shutdown = 1'b1;
        end
        // Mode follows on the 32kHz tick, so a brief pin glitch only toggles power if it falls on a tick
        if (tick32) begin
            nxt_sleep = pin_doze | shutdown_ff;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            shutdown_ff <= 1'b0;
            sleep_ff    <= 1'b0;
        end else begin
            shutdown_ff <= nxt_shutdown;
            sleep_ff    <= nxt_sleep;
        end
    end

    // Configuration registers
    logic [1:0]      mon_ff;
    logic [ST_W-1:0] mask_ff;
    logic [IO_N-1:0] dir_ff;
    logic [IO_N-1:0] pull_ff;
    logic [1:0]      nxt_mon;
    logic [ST_W-1:0] nxt_mask;
    logic [IO_N-1:0] nxt_dir;
    logic [IO_N-1:0] nxt_pull;

    always_comb begin
        nxt_mon  = mon_ff;
        nxt_mask = mask_ff;
        nxt_dir  = dir_ff;
        nxt_pull = pull_ff;
        if (wr_mon) begin
            nxt_mon = wdata_i[1:0];
        end
        if (wr_mask) begin
            nxt_mask = wdata_i[ST_W-1:0];
        end
        if (wr_io) begin
            nxt_dir  = wdata_i[IO_N-1:0];
            nxt_pull = wdata_i[2*IO_N-1:IO_N];
        end
    end

    // Power-up leaves pins as pulled-up inputs and only clock-locked unmasked
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mon_ff  <= SUPPLY_MON_RST;
            mask_ff <= MASK_RST;
            dir_ff  <= IO_DIR_RST;
            pull_ff <= IO_PULL_RST;
        end else begin
            mon_ff  <= nxt_mon;
            mask_ff <= nxt_mask;
            dir_ff  <= nxt_dir;
            pull_ff <= nxt_pull;
        end
    end

    // Sticky status: set wins over write-one clear and over read clear
    logic [ST_W-1:0] status_ff;
    logic [ST_W-1:0] nxt_status;
    logic [ST_W-1:0] st_set;

    always_comb begin
        st_set                = '0;
        st_set[ST_WAKE_PIN]   = wake_evt;
        st_set[ST_DAY_ALARM]  = alarm_evt;
        st_set[ST_LOW_SUPPLY] = low_sup;
        st_set[ST_CLK_LOCKED] = sy.rise[IN_LOCKED];
        nxt_status = status_ff;
        if (wr_status) begin
            nxt_status = nxt_status & ~wdata_i[ST_W-1:0];
        end
        // Low supply drops on a status read; a live condition sets it again
        if (rd_status) begin
            nxt_status[ST_LOW_SUPPLY] = 1'b0;
        end
        nxt_status = nxt_status | st_set;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status_ff <= '0;
        end else begin
            status_ff <= nxt_status;
        end
    end

    // Reset output and read data
    logic                reset_n_ff;
    logic                nxt_reset_n;
    logic [DATA_W-1:0]   rdata_ff;
    logic [DATA_W-1:0]   nxt_rdata;

    always_comb begin
        // Supply trip only resets when the enable field is zero
        nxt_reset_n = ~((low_sup & ~mon_ff[RESET_OUTPUT_ENABLE])
                        | sy.lvl[IN_WDOG]
                        | sy.lvl[IN_XTAL]
                        | ~sy.lvl[IN_CLK32_OK]);
        nxt_rdata = '0;
        if (rd_i) begin
            unique case (addr_i)
                OFS_SLEEP_CFG: begin
                    nxt_rdata[DOZE_REQUEST_BIT] = shutdown_ff;
                end
                OFS_SUPPLY_MON: begin
                    nxt_rdata[1:0] = mon_ff;
                end
                OFS_STATUS: begin
                    nxt_rdata[ST_W-1:0] = status_ff;
                end
                OFS_MASK: begin
                    nxt_rdata[ST_W-1:0] = mask_ff;
                end
                OFS_IO_CFG: begin
                    nxt_rdata = {pull_ff, dir_ff};
                end
                OFS_MODE: begin
                    nxt_rdata[MD_SLEEP]    = sleep_ff;
                    nxt_rdata[MD_SHUTDOWN] = shutdown_ff;
                    nxt_rdata[MD_PIN_DOZE] = pin_doze;
                    nxt_rdata[MD_RESET_N]  = reset_n_ff;
                end
                default: begin
                    nxt_rdata = '0; // Unmapped and command addresses read zero
                end
            endcase
        end
    end

    // Power-on reset holds the reset output low
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            reset_n_ff <= 1'b0;
            rdata_ff   <= '0;
        end else begin
            reset_n_ff <= nxt_reset_n;
            rdata_ff   <= nxt_rdata;
        end
    end

    // Outputs; the pump stays off in sleep along with the other analog blocks
    assign rdata_o       = rdata_ff;
    assign reset_n_o     = reset_n_ff;
    assign irq_o         = |(status_ff & ~mask_ff);
    assign sleep_mode_o  = sleep_ff;
    assign block_power_o = ~sleep_ff;
    assign pump_on_o     = mon_ff[PUMP_ENABLE_BIT] & ~sleep_ff;
    assign io_dir_o      = dir_ff;
    assign io_pullup_o   = pull_ff;

endmodule : swrc_top

// ==== bench/swrc_host_model.sv ====
`timescale 1ns/1ns
// Far side: stands in for the 32 kHz source on the board, free running with a 320 ns period
module swrc_host_model (
    output logic clk32k_o
);
    // Odd start offset keeps its edges clear of the system clock
    initial begin
        clk32k_o = 1'b0;
        #7;
        forever #160 clk32k_o = ~clk32k_o;
    end
endmodule : swrc_host_model

// ==== bench/swrc_top_sva.sv ====
`timescale 1ns/1ns
module swrc_top_sva (
    input wire logic                        clk_i,
    input wire logic                        rst_i,
    input wire logic                        rd_i,
    input wire logic [swrc_pkg::DATA_W-1:0] rdata_o,
    input wire logic                        supply_low_i,
    input wire logic                        watchdog_expired_i,
    input wire logic                        xtal_attached_i,
    input wire logic                        clk32_ready_i,
    input wire logic                        reset_n_o,
    input wire logic                        irq_o,
    input wire logic                        sleep_mode_o,
    input wire logic                        block_power_o,
    input wire logic                        pump_on_o,
    input wire logic [swrc_pkg::IO_N-1:0]   io_dir_o,
    input wire logic [swrc_pkg::IO_N-1:0]   io_pullup_o
);
    import swrc_pkg::*;
    // One domain, so one clock and one reset for all
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    chk_power_gate: assert property (block_power_o == !sleep_mode_o)
        else $error("block power not inverse of sleep");
    chk_pump_sleep: assert property (sleep_mode_o |-> !pump_on_o)
        else $error("pump on during sleep");
    chk_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
        else $error("read data outside answer cycle");
    // Sync stages plus register give the margin of five samples
    chk_reset_src: assert property ((watchdog_expired_i
        || xtal_attached_i || !clk32_ready_i) [*5] |-> !reset_n_o)
        else $error("reset output high with a reset source");
    chk_reset_free: assert property ((!watchdog_expired_i
        && !xtal_attached_i && clk32_ready_i && !supply_low_i) [*6] |-> reset_n_o)
        else $error("reset output low without a source");
    chk_io_default: assert property ($fell(rst_i) |->
        io_dir_o == 4'h0 && io_pullup_o == 4'hf)
        else $error("user pins not inputs with pull-ups after reset");
    chk_irq_default: assert property ($fell(rst_i) |-> !irq_o)
        else $error("interrupt high after reset");
    chk_mode_default: assert property ($fell(rst_i) |->
        !sleep_mode_o && block_power_o && !pump_on_o)
        else $error("not in normal mode with pump off after reset");
endmodule : swrc_top_sva

bind swrc_top swrc_top_sva chk_u (.clk_i, .rst_i, .rd_i, .rdata_o, .supply_low_i,
    .watchdog_expired_i, .xtal_attached_i, .clk32_ready_i, .reset_n_o, .irq_o,
    .sleep_mode_o, .block_power_o, .pump_on_o, .io_dir_o, .io_pullup_o);

// ==== bench/tb_swrc_top.sv ====
`timescale 1ns/1ns
module tb_swrc_top;
    import swrc_pkg::*;
    logic       clk_i, rst_i, wr_i, rd_i, rd_d, clk32k_i;
    logic       doze_pin_i, wake_pin_i, day_alarm_i, supply_low_i, watchdog_expired_i;
    logic       xtal_attached_i, clk32_ready_i, fast_clock_locked_i;
    logic       reset_n_o, irq_o, sleep_mode_o, block_power_o, pump_on_o;
    logic [7:0] addr_i, wdata_i, rdata_o;
    logic [7:0] rnd;
    logic [3:0] io_dir_o, io_pullup_o;
    logic [7:0] exp_q[$];
    int         fails, cmp_count;

    swrc_top dut_u (.clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
        .doze_pin_i, .wake_pin_i, .day_alarm_i, .clk32k_i, .supply_low_i,
        .watchdog_expired_i, .xtal_attached_i, .clk32_ready_i, .fast_clock_locked_i,
        .reset_n_o, .irq_o, .sleep_mode_o, .block_power_o, .pump_on_o, .io_dir_o,
        .io_pullup_o);
    swrc_host_model host_u (.clk32k_o(clk32k_i));

    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic end_sim;
        $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_sim

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask : wr

    // Note the expected answer; the monitor compares it later
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk_i);
        rd_i <= 1'b0;
    endtask : rd

    function automatic logic pick(input int s);
        case (s)
            0: pick = sleep_mode_o;
            1: pick = reset_n_o;
            2: pick = irq_o;
            default: pick = pump_on_o;
        endcase
    endfunction : pick

    // Mode changes wait for a 32 kHz tick, so the bound covers several ticks
    // Outputs are read at the falling edge, where they have settled
    task automatic wait_sig(input int s, input logic v);
        int n;
        n = 0;
        @(negedge clk_i);
        while (pick(s) !== v && n < 60) begin
            @(negedge clk_i);
            n++;
        end
        check({7'h00, pick(s)}, {7'h00, v});
        if (n >= 60) end_sim();
        @(posedge clk_i);
    endtask : wait_sig

    // Output must show the value once, after 20 cycles spanning a few ticks; looked at mid-cycle
    task automatic hold_sig(input int s, input logic v);
        repeat (20) @(negedge clk_i);
        check({7'h00, pick(s)}, {7'h00, v});
        @(posedge clk_i);
    endtask : hold_sig

    // Answer stands only in the cycle after the strobe; sample mid-cycle
    always @(posedge clk_i) rd_d <= rd_i;
    always @(negedge clk_i) begin
        if (rd_d === 1'b1 && exp_q.size() > 0) check(rdata_o, exp_q.pop_front());
    end

    initial begin
        rst_i = 1'b1;
        wr_i = 1'b0;
        rd_i = 1'b0;
        addr_i = 8'h00;
        wdata_i = 8'h00;
        doze_pin_i = 1'b0;
        wake_pin_i = 1'b0;
        day_alarm_i = 1'b0;
        supply_low_i = 1'b0;
        watchdog_expired_i = 1'b0;
        xtal_attached_i = 1'b0;
        clk32_ready_i = 1'b1;
        fast_clock_locked_i = 1'b0;
        fails = 0;
        cmp_count = 0;
        void'($urandom(26));
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        wait_sig(1, 1'b1);
        check({io_pullup_o, io_dir_o}, 8'hf0);
        rd(OFS_MASK, 8'h07);
        rd(OFS_IO_CFG, 8'hf0);
        rd(OFS_SUPPLY_MON, 8'h00);
        rd(8'h20, 8'h00);
        // Pin configuration takes any value and shows it on the pins
        rnd = 8'($urandom);
        wr(OFS_IO_CFG, rnd);
        rd(OFS_IO_CFG, rnd);
        check({io_pullup_o, io_dir_o}, rnd);
        fast_clock_locked_i <= 1'b1;
        wait_sig(2, 1'b1);
        rd(OFS_STATUS, 8'h08);
        wr(OFS_STATUS, 8'h08);
        wait_sig(2, 1'b0);
        $display("test reset_defaults done");
        // Normal-mode settings go in before sleep is asked for
        wr(OFS_SUPPLY_MON, 8'h02);
        wait_sig(3, 1'b1);
        wr(OFS_SLEEP_CMD, 8'($urandom));
        wait_sig(0, 1'b1);
        check({6'h00, block_power_o, pump_on_o}, 8'h00);
        rd(OFS_MODE, 8'h0b);
        wr(OFS_NORMAL_CMD, 8'($urandom));
        wait_sig(0, 1'b0);
        wait_sig(3, 1'b1);
        wr(OFS_SLEEP_CFG, 8'h01);
        wait_sig(0, 1'b1);
        rd(OFS_SLEEP_CFG, 8'h01);
        wake_pin_i <= 1'b1;
        wait_sig(0, 1'b0);
        wake_pin_i <= 1'b0;
        wr(OFS_SLEEP_CMD, 8'($urandom));
        wait_sig(0, 1'b1);
        day_alarm_i <= 1'b1;
        wait_sig(0, 1'b0);
        day_alarm_i <= 1'b0;
        rd(OFS_STATUS, 8'h03);
        wr(OFS_STATUS, 8'h03);
        $display("test software_sleep done");
        // Shutdown set under the pin must survive a normal write and a wake edge
        doze_pin_i <= 1'b1;
        wait_sig(0, 1'b1);
        wr(OFS_SLEEP_CMD, 8'h00);
        wr(OFS_NORMAL_CMD, 8'h00);
        wake_pin_i <= 1'b1;
        hold_sig(0, 1'b1);
        wake_pin_i <= 1'b0;
        rd(OFS_MODE, 8'h0f);
        doze_pin_i <= 1'b0;
        hold_sig(0, 1'b1);
        wr(OFS_NORMAL_CMD, 8'h00);
        wait_sig(0, 1'b0);
        doze_pin_i <= 1'b1;
        wait_sig(0, 1'b1);
        doze_pin_i <= 1'b0;
        wait_sig(0, 1'b0);
        wr(OFS_STATUS, 8'h01);
        wake_pin_i <= 1'b1;
        hold_sig(0, 1'b0);
        wake_pin_i <= 1'b0;
        rd(OFS_STATUS, 8'h01);
        wr(OFS_STATUS, 8'h01);
        $display("test pin_doze done");
        supply_low_i <= 1'b1;
        wait_sig(1, 1'b0);
        wr(OFS_SUPPLY_MON, 8'h01);
        wait_sig(1, 1'b1);
        wait_sig(3, 1'b0);
        wr(OFS_MASK, 8'h03);
        wait_sig(2, 1'b1);
        rd(OFS_STATUS, 8'h04);
        supply_low_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        rd(OFS_STATUS, 8'h04);
        rd(OFS_STATUS, 8'h00);
        wait_sig(2, 1'b0);
        $display("test supply_monitor done");
        for (int i = 0; i < 3; i++) begin
            watchdog_expired_i <= (i == 0);
            xtal_attached_i    <= (i == 1);
            clk32_ready_i      <= (i != 2);
            wait_sig(1, 1'b0);
            watchdog_expired_i <= 1'b0;
            xtal_attached_i    <= 1'b0;
            clk32_ready_i      <= 1'b1;
            wait_sig(1, 1'b1);
        end
        $display("test reset_sources done");
        end_sim();
    end
endmodule : tb_swrc_top
